// ---- common/output_path_defines.vh ----
// constants for the output path and volume control block
//
// Behaviour
// - both speaker outputs float when powered down or speaker unused
// - speaker driver follows the speaker enable bit, enabled by default
// - output type bit makes the auxiliary output current or voltage mode
// - auxiliary output defaults to current mode
// - auxiliary output powers down when its power bit asks for it
// - auxiliary output defaults to powered on
// - exactly eight volume levels
// - each accepted low pulse on the step button moves volume one level, downward at first, except in a cycle with a config write or reload
// - after minimum, pulses raise volume to maximum, then down again, forever
// - power-up and reset load volume from stored configuration
// - stored default volume is the maximum level
// - volume may also be set directly by the three-bit level field
// - step button debounced at both press and release
// - low reset puts the block in a known state with defaults
`ifndef OUTPUT_PATH_DEFINES_VH
`define OUTPUT_PATH_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONFIG        8'h00
`define OFS_STORED        8'h04
`define OFS_STATUS        8'h08
`define OFS_CONTROL       8'h0C

// ----------------------------------------------------------------------
// field positions of the analog path configuration word and the control word
// ----------------------------------------------------------------------
`define LEVEL_LSB         0
`define LEVEL_MSB         2
`define TYPE_BIT          7
`define SPK_EN_BIT        8
`define AUX_PWR_BIT       9
`define CTRL_PWRDN_BIT    0
`define CTRL_RELOAD_BIT   1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LEVEL_MAX         3'h7
`define LEVEL_MIN         3'h0
`define SPK_EN_RESET      1'h1
`define TYPE_RESET        1'h0
`define AUX_PWR_RESET     1'h0
`define PWRDN_RESET       1'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define DEBOUNCE_NS       20000000
`define DEBOUNCE_CYCLES   (`DEBOUNCE_NS / `CLK_PERIOD_NS)

`endif

// ---- hdl/step_debounce.v ----
// debounce filter for the volume step push button
`timescale 1ns/100ps

module step_debounce #(
    parameter integer CYCLES = 2000000,   // stable time needed
    parameter integer CW     = 21         // counter width
) (
    input  wire hclk,                     // system clock
    input  wire hresetn,                  // async reset, active low
    input  wire raw_n,                    // button, already synchronised
    output reg  press                     // one pulse per accepted press
);

    reg          stable_n;                // filtered level
    reg [CW-1:0] count;                   // time the raw level differed

    // --------------------------------------------------------------
    // filter: a change must hold for CYCLES at press and release
    // --------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stable_n <= 1'b1;
            count    <= {CW{1'b0}};
            press    <= 1'b0;
        end else begin
            press <= 1'b0;
            if (raw_n == stable_n) begin
                count <= {CW{1'b0}};       // bounce restarts the wait
            end else if (count == CYCLES[CW-1:0] - 1'b1) begin
                count    <= {CW{1'b0}};
                stable_n <= raw_n;         // level accepted at both edges
                press    <= ~raw_n;        // only the low-going edge counts
            end else begin
                count <= count + 1'b1;
            end
        end
    end

endmodule

// ---- hdl/output_path_volume_control.v ----
// output stage enables and eight-level volume control behind AHB-Lite
`timescale 1ns/100ps
`include "output_path_defines.vh"

module output_path_volume_control #(
    parameter integer DEBOUNCE = `DEBOUNCE_CYCLES, // press/release stable time
    parameter integer DB_W     = 21                // debounce counter width
) (
    input  wire        hclk,                    // 100 MHz bus clock
    input  wire        hresetn,                 // async reset, active low
    input  wire        hsel,                    // slave select
    input  wire [31:0] haddr,                   // byte address
    input  wire [1:0]  htrans,                  // transfer type
    input  wire        hwrite,                  // write when high
    input  wire [2:0]  hsize,                   // transfer size
    input  wire        hready,                  // bus ready in
    input  wire [31:0] hwdata,                  // write data
    output reg  [31:0] hrdata,                  // read data
    output reg         hreadyout,               // always ready
    output reg         hresp,                   // always OKAY
    input  wire        level_step_button_n,     // push button, active low pin
    output reg         speaker_out_positive,    // pwm drive, positive side
    output reg         speaker_out_negative,    // pwm drive, negative side
    output reg         speaker_out_oe_n,        // low while speaker driven
    output reg         aux_output_on,           // auxiliary output powered
    output reg         current_mode_output,     // high: current, low: voltage
    output reg  [2:0]  volume_level             // 0 minimum .. 7 maximum
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    reg        speaker_enable_bit;             // speaker driver enable
    reg        output_type_select_bit;         // 0 current, 1 voltage
    reg        aux_power_bit;                  // 1 powers auxiliary down
    reg  [2:0] stored_level;                   // non-volatile image
    reg  [2:0] level;                          // live volume
    reg        rising;                         // ping-pong direction
    reg        power_down;                     // software power down
    reg        boot;                           // load pending after reset
    reg  [1:0] btn_sync;                       // two-stage synchroniser
    reg        pend_valid;                     // captured address phase
    reg        pend_write;
    reg  [7:0] pend_addr;
    reg  [7:0] pwm_cnt;                        // simple pwm ramp
    wire       press;

    // decode of a word offset, used for read and write
    function [1:0] reg_index;
        input [7:0] a;
        begin
            case (a)
                `OFS_CONFIG:  reg_index = 2'h0;
                `OFS_STORED:  reg_index = 2'h1;
                `OFS_STATUS:  reg_index = 2'h2;
                default:      reg_index = 2'h3;
            endcase
        end
    endfunction

    // --------------------------------------------------------------
    // button synchroniser and debounce
    // --------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            btn_sync <= 2'h3;
        end else begin
            btn_sync <= {btn_sync[0], level_step_button_n};
        end
    end

    step_debounce #(
        .CYCLES (DEBOUNCE),
        .CW     (DB_W)
    ) u_debounce (
        .hclk    (hclk),
        .hresetn (hresetn),
        .raw_n   (btn_sync[1]),
        .press   (press)
    );

    // --------------------------------------------------------------
    // AHB-Lite address phase capture; zero wait states
    // --------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_valid <= 1'b0;
            pend_write <= 1'b0;
            pend_addr  <= 8'h00;
        end else if (hready) begin
            pend_valid <= hsel & htrans[1];
            pend_write <= hwrite;
            pend_addr  <= haddr[7:0];
        end
    end

    wire wr     = pend_valid & pend_write;
    wire rd_now = hsel & htrans[1] & hready & ~hwrite;
    wire [1:0] wr_idx = reg_index(pend_addr);
    wire [1:0] rd_idx = reg_index(haddr[7:0]);
    wire wr_cfg  = wr & (wr_idx == 2'h0) & (pend_addr == `OFS_CONFIG);
    wire wr_sto  = wr & (wr_idx == 2'h1);
    wire wr_ctl  = wr & (pend_addr == `OFS_CONTROL);

    // --------------------------------------------------------------
    // configuration bits, control and stored level
    // --------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speaker_enable_bit     <= `SPK_EN_RESET;
            output_type_select_bit <= `TYPE_RESET;     // current mode
            aux_power_bit          <= `AUX_PWR_RESET;  // powered on
            power_down             <= `PWRDN_RESET;
        end else begin
            if (wr_cfg) begin
                speaker_enable_bit     <= hwdata[`SPK_EN_BIT];
                output_type_select_bit <= hwdata[`TYPE_BIT];
                aux_power_bit          <= hwdata[`AUX_PWR_BIT];
            end
            if (wr_ctl) begin
                power_down <= hwdata[`CTRL_PWRDN_BIT];
            end
        end
    end

    // stored image is not cleared by reset, it models non-volatile memory;
    // its power-on value is the factory maximum
    initial stored_level = `LEVEL_MAX;
    always @(posedge hclk) begin
        if (wr_sto) begin
            stored_level <= hwdata[`LEVEL_MSB:`LEVEL_LSB];
        end
    end

    // --------------------------------------------------------------
    // volume level: reload, direct set, ping-pong stepping
    // --------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot   <= 1'b1;
            level  <= `LEVEL_MAX;
            rising <= 1'b0;
        end else begin
            boot <= 1'b0;
            if (boot || (wr_ctl && hwdata[`CTRL_RELOAD_BIT])) begin
                level  <= stored_level;                // reload after reset
                rising <= 1'b0;
            end else if (wr_cfg) begin
                // code n is level n, same scale as the button
                level  <= hwdata[`LEVEL_MSB:`LEVEL_LSB];
                rising <= 1'b0;
            end else if (press) begin
                if (!rising) begin
                    if (level == `LEVEL_MIN) begin
                        level  <= level + 3'h1;        // turn round at bottom
                        rising <= 1'b1;
                    end else begin
                        level <= level - 3'h1;         // one level down
                    end
                end else begin
                    if (level == `LEVEL_MAX) begin
                        level  <= level - 3'h1;        // turn round at top
                        rising <= 1'b0;
                    end else begin
                        level <= level + 3'h1;         // climb back
                    end
                end
            end
        end
    end

    // --------------------------------------------------------------
    // output stage; all outputs registered
    // --------------------------------------------------------------
    wire spk_live = speaker_enable_bit & ~power_down;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_cnt              <= 8'h00;
            speaker_out_positive <= 1'b0;
            speaker_out_negative <= 1'b0;
            speaker_out_oe_n     <= 1'b1;
            aux_output_on        <= 1'b0;
            current_mode_output  <= 1'b1;
            volume_level         <= `LEVEL_MAX;        // three bits, eight levels
        end else begin
            pwm_cnt              <= pwm_cnt + 8'h01;
            // float both sides unless in use
            speaker_out_oe_n     <= ~spk_live;
            speaker_out_positive <= spk_live & (pwm_cnt[7:5] < level);
            speaker_out_negative <= spk_live & ~(pwm_cnt[7:5] < level);
            aux_output_on        <= ~aux_power_bit & ~power_down;
            current_mode_output  <= ~output_type_select_bit;
            volume_level         <= level;
        end
    end

    // --------------------------------------------------------------
    // read data and response
    // --------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_now) begin
                case (rd_idx)
                    2'h0: hrdata <= {22'h000000, aux_power_bit, speaker_enable_bit,
                                     output_type_select_bit, 4'h0, level};
                    2'h1: hrdata <= {29'h00000000, stored_level};
                    2'h2: hrdata <= {26'h0000000, rising, speaker_out_oe_n,
                                     ~btn_sync[1], level};
                    default: hrdata <= (haddr[7:0] == `OFS_CONTROL) ?
                                       {31'h00000000, power_down} : 32'h00000000;
                endcase
            end
        end
    end

endmodule

// ---- sim/output_path_checker.sv ----
// concurrent checks on the output path and volume block ports
`timescale 1ns/100ps
`include "output_path_defines.vh"
module output_path_checker #(
    parameter integer DEBOUNCE = 8          // press stable time
) (
    input wire        hclk,                 // bus clock
    input wire        hresetn,              // reset, active low
    input wire        hsel,                 // select
    input wire [31:0] haddr,                // address
    input wire [1:0]  htrans,               // transfer type
    input wire        hwrite,               // write
    input wire        hready,               // bus ready
    input wire [31:0] hwdata,               // write data
    input wire        hreadyout,            // slave ready
    input wire        hresp,                // response
    input wire        level_step_button_n,  // button pin
    input wire        speaker_out_positive, // speaker plus
    input wire        speaker_out_negative, // speaker minus
    input wire        speaker_out_oe_n,     // speaker float
    input wire        aux_output_on,        // aux powered
    input wire        current_mode_output,  // aux type
    input wire [2:0]  volume_level          // level
);
    reg        wr_ph;
    reg [7:0]  a_q;
    reg [31:0] wd;
    reg [2:0]  wcnt;
    int        lowcnt;
    wire       cfg_wr = wr_ph && (a_q == `OFS_CONFIG);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // quiet window after bus writes so direct sets are not taken as presses
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph  <= 1'b0;
            a_q    <= 8'h00;
            wd     <= 32'h0;
            wcnt   <= 3'h4;
            lowcnt <= 0;
        end else begin
            wr_ph  <= hsel & htrans[1] & hready & hwrite;
            a_q    <= haddr[7:0];
            wd     <= cfg_wr ? hwdata : wd;
            wcnt   <= (wr_ph || hsel) ? 3'h4 : ((wcnt == 3'h0) ? 3'h0 : wcnt - 3'h1);
            lowcnt <= level_step_button_n ? 0 : ((lowcnt < 1000) ? lowcnt + 1 : lowcnt);
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_idle_quiet: assert property (speaker_out_oe_n |-> !speaker_out_positive && !speaker_out_negative)
        else $error("speaker driven while floating");
    a_spk_disable: assert property (cfg_wr && !hwdata[8] |=> ##1 speaker_out_oe_n)
        else $error("speaker not floated");
    a_aux_down: assert property (cfg_wr && hwdata[9] |=> ##1 !aux_output_on)
        else $error("aux output not powered down");
    a_type_sel: assert property (cfg_wr |=> ##1 current_mode_output == !wd[7])
        else $error("aux output type wrong");
    a_level_set: assert property (cfg_wr |=> ##1 volume_level == wd[2:0])
        else $error("direct level not applied");
    a_step_one: assert property ($changed(volume_level) && wcnt == 3'h0 |->
        volume_level == $past(volume_level) + 3'h1 || volume_level == $past(volume_level) - 3'h1)
        else $error("level step not one");
    a_turn_min: assert property ($changed(volume_level) && wcnt == 3'h0 && $past(volume_level) == 3'h0
        |-> volume_level == 3'h1)
        else $error("no turn at minimum");
    a_turn_max: assert property ($changed(volume_level) && wcnt == 3'h0 && $past(volume_level) == 3'h7
        |-> volume_level == 3'h6)
        else $error("no turn at maximum");
    a_debounce_held: assert property ($changed(volume_level) && wcnt == 3'h0 |-> lowcnt >= DEBOUNCE)
        else $error("step without stable press");
    a_reset_defaults: assert property ($rose(hresetn) |-> volume_level == 3'h7 && speaker_out_oe_n
        ##1 !speaker_out_oe_n && aux_output_on && current_mode_output)
        else $error("reset defaults wrong");
    c_press: cover property ($changed(volume_level) && wcnt == 3'h0);
    c_cfg: cover property (cfg_wr);
    c_reset: cover property ($rose(hresetn));
endmodule
bind output_path_volume_control output_path_checker #(.DEBOUNCE(DEBOUNCE)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .level_step_button_n(level_step_button_n), .speaker_out_positive(speaker_out_positive),
    .speaker_out_negative(speaker_out_negative), .speaker_out_oe_n(speaker_out_oe_n),
    .aux_output_on(aux_output_on), .current_mode_output(current_mode_output),
    .volume_level(volume_level));

// ---- sim/push_button_model.sv ----
// push button with contact chatter, pulled up when open
`timescale 1ns/100ps
module push_button_model (
    input  wire hclk,   // timing for the chatter
    input  wire push,   // finger on the key
    output reg  btn_n   // contact, low while closed
);
    integer k;
    initial btn_n = 1'b1;
    // chatter on press and release alike, so both ends need filtering
    always @(push) begin
        for (k = 0; k < 5; k = k + 1) begin
            @(posedge hclk);
            btn_n <= ~btn_n;
        end
        @(posedge hclk);
        btn_n <= ~push;
    end
endmodule

// ---- sim/output_path_volume_control_tb_top.sv ----
// self-checking bench for the output path and volume block
`timescale 1ns/100ps
`include "output_path_defines.vh"
module output_path_volume_control_tb_top;
    localparam integer DB = 8;  // short debounce keeps presses fast
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg         push = 1'b0;
    reg  [31:0] rd;
    wire [31:0] hrdata;
    wire        hready, hresp, btn_n, sp_p, sp_n, oe_n, aux_on, cur_mode;
    wire [2:0]  level;
    integer     n_errors = 0;
    integer     cmp_count = 0;
    integer     cyc = 0;
    always #5 hclk = ~hclk;
    output_path_volume_control #(.DEBOUNCE(DB), .DB_W(21)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .level_step_button_n(btn_n),
        .speaker_out_positive(sp_p), .speaker_out_negative(sp_n), .speaker_out_oe_n(oe_n),
        .aux_output_on(aux_on), .current_mode_output(cur_mode), .volume_level(level));
    push_button_model btn (.hclk(hclk), .push(push), .btn_n(btn_n));
    task conclude;
        begin
            $display("compares %0d mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wait_ready;
        begin
            @(posedge hclk);
            while (hready !== 1'b1)
                @(posedge hclk);
        end
    endtask
    // single word transfer; read data lands in rd, outputs settle after
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= {24'h0, a};
            htrans <= 2'h2;
            hwrite <= w;
            wait_ready;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            wait_ready;
            rd = hrdata;
            repeat (2) @(posedge hclk);
        end
    endtask
    task t_defaults;
        begin
            chk(level, 3'h7);
            chk({oe_n, aux_on, cur_mode, sp_p ^ sp_n}, 4'h7);
            bus(1'b0, `OFS_CONFIG, 32'h0);
            chk(rd, 32'h0000_0107);
            bus(1'b0, 8'h10, 32'h0);
            chk(rd, 32'h0);
        end
    endtask
    task t_config;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                bus(1'b1, `OFS_CONFIG, {22'h0, i[2:0], 4'h0, i[2:0]});
                chk(level, i[2:0]);
                chk({oe_n, aux_on, cur_mode}, {~i[1], ~i[2], ~i[0]});
            end
            bus(1'b1, `OFS_CONFIG, 32'h0000_0107);
            bus(1'b1, `OFS_CONTROL, 32'h1);
            chk({oe_n, sp_p, sp_n, aux_on}, 4'h8);
            bus(1'b1, `OFS_CONTROL, 32'h0);
            chk({oe_n, aux_on}, 2'h1);
        end
    endtask
    // chattering presses walk the level down, back up and down again
    task t_ping_pong;
        integer k, t;
        reg [2:0] exp, prev;
        reg       dn;
        begin
            exp = 3'h7;
            dn = 1'b1;
            for (k = 0; k < 16; k = k + 1) begin
                if (dn && exp == 3'h0)
                    dn = 1'b0;
                else if (!dn && exp == 3'h7)
                    dn = 1'b1;
                exp = dn ? exp - 3'h1 : exp + 3'h1;
                prev = level;
                t = 0;
                push <= 1'b1;
                while (level === prev && t < 80) begin
                    @(posedge hclk);
                    t = t + 1;
                end
                chk(level, exp);
                push <= 1'b0;
                repeat (40) @(posedge hclk);
                chk(level, exp);
            end
        end
    endtask
    task t_reload;
        begin
            bus(1'b1, `OFS_STORED, 32'h3);
            hresetn <= 1'b0;
            repeat (3) @(posedge hclk);
            chk({level, oe_n}, 4'hF);
            hresetn <= 1'b1;
            repeat (3) @(posedge hclk);
            chk(level, 3'h3);
            bus(1'b1, `OFS_CONFIG, 32'h0000_0105);
            bus(1'b1, `OFS_CONTROL, 32'h2);
            chk(level, 3'h3);
        end
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        t_defaults;
        t_config;
        t_ping_pong;
        t_reload;
        conclude;
    end
    // hang guard, well above the roughly one thousand cycles the run needs
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            conclude;
        end
    end
endmodule
